//--- lin_frame_control.v
`timescale 1ns/10ps
`default_nettype none
`include "lin_consts.vh"

module lin_frame_control (
  input  wire                   i_mclk,
  input  wire                   i_rst_b,
  // Indirect register window.
  input  wire [`ADDR_W-1:0]     i_addr,
  input  wire [7:0]             i_wdata,
  input  wire                   i_wr,
  input  wire                   i_rd,
  output reg  [7:0]             o_rdata,
  // Mode and bus engine events.
  input  wire                   i_master_mode,
  input  wire                   i_sync_break,
  input  wire                   i_frame_done,
  input  wire                   i_frame_error,
  input  wire                   i_sleep_frame,
  input  wire                   i_idle_timeout,
  input  wire                   i_wakeup_rx,
  input  wire                   i_wakeup_sent,
  input  wire                   i_data_id_rx,
  input  wire                   i_int_event,
  input  wire [`ERR_BITS-1:0]   i_err_event,
  input  wire                   i_bus_active,
  input  wire                   i_abort,
  // Bus engine byte path.
  input  wire                   i_rx_byte_wr,
  input  wire [`BUF_IDX_W-1:0]  i_rx_byte_idx,
  input  wire [7:0]             i_rx_byte,
  input  wire [`BUF_IDX_W-1:0]  i_tx_byte_idx,
  output wire [7:0]             o_tx_byte,
  // Controls toward the bus engine.
  output wire                   o_start_request,
  output wire                   o_frame_direction,
  output wire                   o_data_ack,
  output wire                   o_halted,
  output wire                   o_sleeping,
  output wire                   o_wakeup_drive
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode.

  wire       slave_mode;
  wire       ctl_wr;
  wire       byte_wr;
  wire       byte_hit;
  wire [7:0] byte_rd;

  assign slave_mode = ~i_master_mode;
  assign ctl_wr     = i_wr && (i_addr == `ADDR_CONTROL);
  assign byte_hit   = (i_addr <= `ADDR_BYTE_LAST);
  assign byte_wr    = i_wr && byte_hit;

  wire halt_wr;
  wire int_clr_wr;
  wire err_clr_wr;
  wire ack_wr;
  wire wake_wr;
  wire start_wr;

  // Strobes act only on a one; a zero written is no action.
  assign halt_wr    = ctl_wr && i_wdata[`CTL_HALT]
                      && slave_mode;
  assign int_clr_wr = ctl_wr && i_wdata[`CTL_INT_CLEAR];
  assign err_clr_wr = ctl_wr && i_wdata[`CTL_ERR_CLEAR];
  assign ack_wr     = ctl_wr && i_wdata[`CTL_DATA_ACK]
                      && slave_mode;
  assign wake_wr    = ctl_wr && i_wdata[`CTL_WAKEUP_REQ];
  assign start_wr   = ctl_wr && i_wdata[`CTL_START_REQ]
                      && i_master_mode;

  ////////////////////////////////////////////////////////////////////////////
  // Data buffer.

  wire rx_take;

  // While halted the engine's captures are dropped so stale frames
  // cannot overwrite bytes software is preparing.
  assign rx_take = i_rx_byte_wr && !o_halted;

  frame_byte_buffer u_buf (
    .i_mclk     (i_mclk),
    .i_rst_b    (i_rst_b),
    .i_sw_wr    (byte_wr),
    .i_sw_idx   (i_addr[`BUF_IDX_W-1:0]),
    .i_sw_data  (i_wdata),
    .i_bus_wr   (rx_take),
    .i_bus_idx  (i_rx_byte_idx),
    .i_bus_data (i_rx_byte),
    .i_rd_a_idx (i_addr[`BUF_IDX_W-1:0]),
    .o_rd_a     (byte_rd),
    .i_rd_b_idx (i_tx_byte_idx),
    .o_rd_b     (o_tx_byte)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Stored control bits.

  reg sleep_en_q;
  reg sleep_en_d;
  reg direction_q;
  reg direction_d;
  reg data_ack_q;
  reg data_ack_d;
  reg wakeup_q;
  reg wakeup_d;
  reg start_q;
  reg start_d;

  always @* begin
    sleep_en_d  = sleep_en_q;
    direction_d = direction_q;
    if (ctl_wr) begin
      direction_d = i_wdata[`CTL_DIRECTION];
      if (slave_mode) begin
        sleep_en_d = i_wdata[`CTL_SLEEP];
      end
    end
  end

  // Acknowledge lives exactly one cycle; the engine sees it as a pulse.
  always @* begin
    data_ack_d = 1'b0;
    if (ack_wr) begin
      data_ack_d = 1'b1;
    end
  end

  always @* begin
    wakeup_d = wakeup_q;
    if (wake_wr) begin
      wakeup_d = 1'b1;
    end else if (i_wakeup_sent) begin
      wakeup_d = 1'b0;
    end
  end

  // A start request held across completion would relaunch the frame,
  // so completion and error both drop it.
  always @* begin
    start_d = start_q;
    if (start_wr) begin
      start_d = 1'b1;
    end else if (i_frame_done || i_frame_error) begin
      start_d = 1'b0;
    end
  end

  always @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sleep_en_q  <= 1'b0;
      direction_q <= 1'b0;
      data_ack_q  <= 1'b0;
      wakeup_q    <= 1'b0;
      start_q     <= 1'b0;
    end else begin
      sleep_en_q  <= sleep_en_d;
      direction_q <= direction_d;
      data_ack_q  <= data_ack_d;
      wakeup_q    <= wakeup_d;
      start_q     <= start_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Halt and sleep states.

  localparam [1:0] PWR_AWAKE = 2'b01;
  localparam [1:0] PWR_SLEEP = 2'b10;

  reg [1:0] pwr_q;
  reg [1:0] pwr_d;
  reg       halted_q;
  reg       halted_d;

  // A halt written in the break cycle still takes effect.
  always @* begin
    halted_d = halted_q;
    if (halt_wr) begin
      halted_d = 1'b1;
    end else if (i_sync_break) begin
      halted_d = 1'b0;
    end
  end

  always @* begin
    pwr_d = pwr_q;
    case (pwr_q)
      PWR_AWAKE: begin
        if (slave_mode && sleep_en_q
            && (i_sleep_frame || i_idle_timeout)) begin
          pwr_d = PWR_SLEEP;
        end
      end
      PWR_SLEEP: begin
        if (wake_wr) begin
          pwr_d = PWR_AWAKE;
        end else if (slave_mode && !sleep_en_q && i_wakeup_rx) begin
          pwr_d = PWR_AWAKE;
        end else if (i_master_mode) begin
          pwr_d = PWR_AWAKE;
        end
      end
      default: begin
        pwr_d = PWR_AWAKE;
      end
    endcase
  end

  always @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pwr_q    <= PWR_AWAKE;
      halted_q <= 1'b0;
    end else begin
      pwr_q    <= pwr_d;
      halted_q <= halted_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status and error flags.

  wire                 int_pending;
  wire                 data_req;
  wire                 err_flag;
  wire [`ERR_BITS-1:0] err_bits;
  wire                 any_err;

  assign any_err = (|i_err_event) || i_frame_error;

  sticky_flag u_int (
    .i_mclk  (i_mclk),
    .i_rst_b (i_rst_b),
    .i_set   (i_int_event),
    .i_clr   (int_clr_wr),
    .o_flag  (int_pending)
  );

  sticky_flag u_dreq (
    .i_mclk  (i_mclk),
    .i_rst_b (i_rst_b),
    .i_set   (i_data_id_rx && slave_mode && !halted_q),
    .i_clr   (ack_wr),
    .o_flag  (data_req)
  );

  sticky_flag u_err (
    .i_mclk  (i_mclk),
    .i_rst_b (i_rst_b),
    .i_set   (any_err),
    .i_clr   (err_clr_wr),
    .o_flag  (err_flag)
  );

  genvar g;
  generate
    for (g = 0; g < `ERR_BITS; g = g + 1) begin : g_err
      sticky_flag u_bit (
        .i_mclk  (i_mclk),
        .i_rst_b (i_rst_b),
        .i_set   (i_err_event[g]),
        .i_clr   (err_clr_wr),
        .o_flag  (err_bits[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Register read.

  reg [7:0] ctl_rd;
  reg [7:0] st_rd;
  reg [7:0] rd_d;

  always @* begin
    ctl_rd                  = `CONTROL_RESET;
    ctl_rd[`CTL_HALT]       = 1'b0;
    ctl_rd[`CTL_SLEEP]      = sleep_en_q;
    ctl_rd[`CTL_DIRECTION]  = direction_q;
    ctl_rd[`CTL_DATA_ACK]   = data_ack_q;
    ctl_rd[`CTL_INT_CLEAR]  = 1'b0;
    ctl_rd[`CTL_ERR_CLEAR]  = 1'b0;
    ctl_rd[`CTL_WAKEUP_REQ] = wakeup_q;
    ctl_rd[`CTL_START_REQ]  = start_q;
  end

  always @* begin
    st_rd                   = `CONTROL_RESET;
    st_rd[`ST_ACTIVE]       = i_bus_active;
    st_rd[`ST_IDLE_TIMEOUT] = i_idle_timeout && slave_mode;
    st_rd[`ST_ABORT]        = i_abort && slave_mode;
    st_rd[`ST_DATA_REQ]     = data_req;
    st_rd[`ST_INT_PENDING]  = int_pending;
    st_rd[`ST_ERROR]        = err_flag;
    st_rd[`ST_WAKEUP]       = wakeup_q || i_wakeup_rx;
    st_rd[`ST_DONE]         = i_frame_done;
  end

  always @* begin
    rd_d = o_rdata;
    if (i_rd) begin
      if (byte_hit) begin
        rd_d = byte_rd;
      end else if (i_addr == `ADDR_CONTROL) begin
        rd_d = ctl_rd;
      end else if (i_addr == `ADDR_STATUS) begin
        rd_d = st_rd;
      end else if (i_addr == `ADDR_ERRORS) begin
        rd_d = {`ERR_PAD, err_bits};
      end else begin
        rd_d = `READ_UNMAPPED;
      end
    end
  end

  always @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= `READ_UNMAPPED;
    end else begin
      o_rdata <= rd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs toward the bus engine.

  assign o_start_request   = start_q;
  assign o_frame_direction = direction_q;
  assign o_data_ack        = data_ack_q;
  assign o_halted          = halted_q;
  assign o_sleeping        = pwr_q[1];
  assign o_wakeup_drive    = wakeup_q;

endmodule

`default_nettype wire

//--- lin_consts.vh
`ifndef LIN_CONSTS_VH
`define LIN_CONSTS_VH

// Indirect register indices.
`define ADDR_W            4
`define ADDR_BYTE_FIRST   4'h0
`define ADDR_BYTE_LAST    4'h7
`define ADDR_CONTROL      4'h8
`define ADDR_STATUS       4'h9
`define ADDR_ERRORS       4'ha

// Control register fields.
`define CTL_HALT          7
`define CTL_SLEEP         6
`define CTL_DIRECTION     5
`define CTL_DATA_ACK      4
`define CTL_INT_CLEAR     3
`define CTL_ERR_CLEAR     2
`define CTL_WAKEUP_REQ    1
`define CTL_START_REQ     0

// Status register fields.
`define ST_ACTIVE         7
`define ST_IDLE_TIMEOUT   6
`define ST_ABORT          5
`define ST_DATA_REQ       4
`define ST_INT_PENDING    3
`define ST_ERROR          2
`define ST_WAKEUP         1
`define ST_DONE           0

// Error register layout.
`define ERR_BITS          5
`define ERR_PAD           3'h0

// Reset values and buffer size.
`define BYTE_RESET        8'h00
`define CONTROL_RESET     8'h00
`define READ_UNMAPPED     8'h00
`define BUF_DEPTH         8
`define BUF_IDX_W         3

`endif

//--- sticky_flag.v
`timescale 1ns/10ps
`default_nettype none

module sticky_flag (
  input  wire i_mclk,
  input  wire i_rst_b,
  input  wire i_set,
  input  wire i_clr,
  output reg  o_flag
);

  // A set in the same cycle as a clear keeps the flag, so no event is lost.
  always @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_flag <= 1'b0;
    end else if (i_set) begin
      o_flag <= 1'b1;
    end else if (i_clr) begin
      o_flag <= 1'b0;
    end
  end

endmodule

`default_nettype wire

//--- frame_byte_buffer.v
`timescale 1ns/10ps
`default_nettype none
`include "lin_consts.vh"

module frame_byte_buffer (
  input  wire                   i_mclk,
  input  wire                   i_rst_b,
  input  wire                   i_sw_wr,
  input  wire [`BUF_IDX_W-1:0]  i_sw_idx,
  input  wire [7:0]             i_sw_data,
  input  wire                   i_bus_wr,
  input  wire [`BUF_IDX_W-1:0]  i_bus_idx,
  input  wire [7:0]             i_bus_data,
  input  wire [`BUF_IDX_W-1:0]  i_rd_a_idx,
  output wire [7:0]             o_rd_a,
  input  wire [`BUF_IDX_W-1:0]  i_rd_b_idx,
  output wire [7:0]             o_rd_b
);

  reg [7:0] mem_q [0:`BUF_DEPTH-1];
  integer   k;

  ////////////////////////////////////////////////////////////////////////////
  // Software access takes the byte when both sides hit the same slot.
  always @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (k = 0; k < `BUF_DEPTH; k = k + 1) begin
        mem_q[k] <= `BYTE_RESET;
      end
    end else begin
      if (i_bus_wr && !(i_sw_wr && i_sw_idx == i_bus_idx)) begin
        mem_q[i_bus_idx] <= i_bus_data;
      end
      if (i_sw_wr) begin
        mem_q[i_sw_idx] <= i_sw_data;
      end
    end
  end

  assign o_rd_a = mem_q[i_rd_a_idx];
  assign o_rd_b = mem_q[i_rd_b_idx];

endmodule

`default_nettype wire

//--- lin_frame_control_properties.sv
`timescale 1ns/10ps
`default_nettype none
`include "lin_consts.vh"
////////////////////////////////////////////////////////////////////////////
module lin_frame_control_properties (
  input wire logic       i_mclk,
  input wire logic       i_rst_b,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       i_master_mode,
  input wire logic       i_sync_break,
  input wire logic       i_frame_done,
  input wire logic       i_frame_error,
  input wire logic       i_wakeup_sent,
  input wire logic       o_start_request,
  input wire logic       o_frame_direction,
  input wire logic       o_data_ack,
  input wire logic       o_halted,
  input wire logic       o_wakeup_drive
);
  wire ctl_wr = i_wr && i_addr == `ADDR_CONTROL;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  sequence s_ack_wr;
    ctl_wr && i_wdata[`CTL_DATA_ACK] && !i_master_mode;
  endsequence
  sequence s_ack_pulse;
    o_data_ack ##1 !o_data_ack;
  endsequence
  a_ack_one_pulse: assert property (
    s_ack_wr ##1 !ctl_wr |-> s_ack_pulse)
    else $error("data acknowledge is not a single pulse");
  a_start_set: assert property (ctl_wr && i_wdata[0] && i_master_mode
    |=> o_start_request) else $error("start request not taken");
  a_start_slave_ignored: assert property (
    !o_start_request && !(ctl_wr && i_master_mode) |=> !o_start_request)
    else $error("start request rose without a master write");
  a_start_clears: assert property (
    o_start_request && (i_frame_done || i_frame_error) && !ctl_wr
    |=> !o_start_request) else $error("start request not cleared");
  a_halt_set: assert property (ctl_wr && i_wdata[7] && !i_master_mode
    |=> o_halted) else $error("halt not taken");
  a_halt_until_break: assert property (o_halted && !i_sync_break
    |=> o_halted) else $error("halt left before a sync break");
  a_halt_master_ignored: assert property (
    !o_halted && !(ctl_wr && !i_master_mode) |=> !o_halted)
    else $error("halt rose without a slave write");
  a_wake_req: assert property (
    ctl_wr && i_wdata[1] |=> o_wakeup_drive)
    else $error("wakeup drive not started");
  a_wake_end: assert property (
    o_wakeup_drive && i_wakeup_sent && !ctl_wr |=> !o_wakeup_drive)
    else $error("wakeup drive not cleared");
  a_dir_track: assert property (
    ctl_wr |=> o_frame_direction == $past(i_wdata[`CTL_DIRECTION]))
    else $error("direction does not follow the write");
  a_strobe_zero: assert property (
    i_rd && i_addr == `ADDR_CONTROL |=> (o_rdata & 8'h8c) == 8'h00)
    else $error("strobe bit read back as one");
endmodule
bind lin_frame_control lin_frame_control_properties
  lin_frame_control_properties_i (
  .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_master_mode(i_master_mode), .i_sync_break(i_sync_break),
  .i_frame_done(i_frame_done), .i_frame_error(i_frame_error),
  .i_wakeup_sent(i_wakeup_sent), .o_start_request(o_start_request),
  .o_frame_direction(o_frame_direction), .o_data_ack(o_data_ack),
  .o_halted(o_halted), .o_wakeup_drive(o_wakeup_drive));
`default_nettype wire

//--- lin_engine_model.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////
module lin_engine_model (
  input  wire logic       i_mclk,
  input  wire logic       i_rst_b,
  input  wire logic       i_start,
  input  wire logic       i_dir,
  input  wire logic       i_wake,
  input  wire logic       i_fail,
  input  wire logic [3:0] i_lat,
  input  wire logic [7:0] i_rx_val,
  output logic            o_done,
  output logic            o_error,
  output logic            o_wsent,
  output logic            o_rx_wr,
  output logic [7:0]      o_rx_byte
);
  logic [3:0] cnt;
  logic [3:0] wcnt;
  // The byte lane toggles when idle so a stale value never looks valid.
  always @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      {cnt, wcnt, o_done, o_error, o_wsent, o_rx_wr} <= 12'h000;
      o_rx_byte <= 8'h00;
    end else begin
      {o_done, o_error, o_wsent, o_rx_wr} <= 4'h0;
      o_rx_byte <= ~o_rx_byte;
      if (i_start && !o_done && !o_error) begin
        cnt <= cnt + 4'h1;
        if (cnt >= i_lat) begin
          cnt <= 4'h0;
          o_done <= !i_fail;
          o_error <= i_fail;
          o_rx_wr <= !i_dir && !i_fail;
          o_rx_byte <= i_rx_val;
        end
      end
      if (i_wake && !o_wsent) begin
        wcnt <= wcnt + 4'h1;
        if (wcnt >= i_lat) begin
          wcnt <= 4'h0;
          o_wsent <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- lin_frame_control_tb.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////
module lin_frame_control_tb;
  logic       i_mclk, i_rst_b, i_wr, i_rd, m, slp, ffail, sbrk, sfr, idle;
  logic       wrx, did, iev, done, err, wsent, rxwr, start, dir, ack, halt;
  logic       sleeping, wake;
  logic [3:0] i_addr, lat;
  logic [4:0] eev;
  logic [7:0] i_wdata, o_rdata, txb, rxv, rxb, d, w, e;
  logic [7:0] bx [8];
  logic [2:0] txi, rxi;
  int         fails, checks, k;
  initial begin
    i_mclk = 0;
    forever #4 i_mclk = ~i_mclk;
  end
  lin_frame_control lin_frame_control_i (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_master_mode(m),
    .i_sync_break(sbrk), .i_frame_done(done), .i_frame_error(err),
    .i_sleep_frame(sfr), .i_idle_timeout(idle), .i_wakeup_rx(wrx),
    .i_wakeup_sent(wsent), .i_data_id_rx(did), .i_int_event(iev),
    .i_err_event(eev), .i_bus_active(1'b0), .i_abort(1'b0),
    .i_rx_byte_wr(rxwr), .i_rx_byte_idx(rxi), .i_rx_byte(rxb),
    .i_tx_byte_idx(txi), .o_tx_byte(txb), .o_start_request(start),
    .o_frame_direction(dir), .o_data_ack(ack), .o_halted(halt),
    .o_sleeping(sleeping), .o_wakeup_drive(wake));
  lin_engine_model lin_engine_model_i (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_start(start), .i_dir(dir),
    .i_wake(wake), .i_fail(ffail), .i_lat(lat), .i_rx_val(rxv),
    .o_done(done), .o_error(err), .o_wsent(wsent), .o_rx_wr(rxwr),
    .o_rx_byte(rxb));
  ////////////////////////////////////////////////////////////////////////
  function logic [7:0] exp_ctl(input logic md, input logic [7:0] v,
                               input logic s);
    return {1'b0, md ? s : v[6], v[5], ~md & v[4], 2'b00, v[1], md & v[0]};
  endfunction
  task cyc(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task wr(input logic [3:0] a, input logic [7:0] v);
    i_addr = a;
    i_wdata = v;
    i_wr = 1;
    cyc(1);
    i_wr = 0;
  endtask
  // The idle edge after a read keeps two reads in a row from moving the
  // strobe twice in one time step; the data stands until the next read.
  task rd(input logic [3:0] a);
    i_addr = a;
    i_rd = 1;
    cyc(1);
    i_rd = 0;
    d = o_rdata;
    cyc(1);
  endtask
  task chk(input string n, input logic [7:0] ex, input logic [7:0] g);
    checks++;
    if (g !== ex) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, ex, g);
    end
  endtask
  task chkb(input string n, input logic ex, input logic g);
    chk(n, {7'h0, ex}, {7'h0, g});
  endtask
  task tally_and_finish;
    if (fails == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Bounded wait for the model to finish any frame or wakeup.
  task settle;
    for (k = 0; k < 60 && (start | wake) !== 1'b0; k++) cyc(1);
    if (k == 60) begin
      fails++;
      tally_and_finish;
    end
  endtask
  task pulse_ev(input int which);
    {sbrk, sfr, idle, wrx, did, iev} = 6'h1 << which;
    cyc(1);
    {sbrk, sfr, idle, wrx, did, iev} = 6'h0;
    cyc(1);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {i_rst_b, i_wr, i_rd, m, slp, ffail, sbrk, sfr, idle, wrx, did} = 0;
    {iev, i_addr, lat, eev, i_wdata, rxv, txi, rxi, fails, checks} = 0;
    void'($urandom(96220));
    cyc(8);
    i_rst_b = 1;
    for (int a = 0; a < 9; a++) begin
      rd(a);
      chk("reset value", 8'h00, d);
    end
    for (int a = 0; a < 8; a++) begin
      bx[a] = $urandom;
      wr(a, bx[a]);
      cyc(1);
    end
    wr(4'hb, 8'hff);
    rd(4'hb);
    chk("unmapped", 8'h00, d);
    for (int i = 0; i < 24; i++) begin
      m = $urandom;
      w = $urandom;
      lat = $urandom % 6;
      ffail = $urandom;
      rxv = $urandom;
      rxi = $urandom;
      wr(8, w);
      chkb("halted", ~m & w[7], halt);
      chkb("start", m & w[0], start);
      chkb("direction", w[5], dir);
      chkb("wakeup drive", w[1], wake);
      rd(8);
      chk("control", exp_ctl(m, w, slp), d);
      slp = m ? slp : w[6];
      settle;
      if (m & w[0] & ~w[5] & ~ffail) begin
        bx[rxi] = rxv;
      end
      pulse_ev(5);
      chkb("halted", 1'b0, halt);
    end
    m = 0;
    pulse_ev(1);
    rd(9);
    chkb("data request", 1'b1, d[4]);
    wr(8, 8'h10);
    chkb("data ack", 1'b1, ack);
    rd(9);
    chkb("data ack", 1'b0, ack);
    chkb("data request", 1'b0, d[4]);
    pulse_ev(0);
    wr(8, 8'h00);
    rd(9);
    chkb("int", 1'b1, d[3]);
    wr(8, 8'h08);
    rd(9);
    chkb("int", 1'b0, d[3]);
    e = $urandom % 32 | 8'h01;
    eev = e[4:0];
    cyc(1);
    eev = 0;
    rd(10);
    chk("errors", e, d);
    rd(9);
    chkb("error", 1'b1, d[2]);
    wr(8, 8'h04);
    rd(10);
    chk("errors", 8'h00, d);
    rd(9);
    chkb("error", 1'b0, d[2]);
    wr(8, 8'h40);
    pulse_ev(4);
    chkb("sleeping", 1'b1, sleeping);
    pulse_ev(2);
    chkb("sleeping", 1'b1, sleeping);
    wr(8, 8'h00);
    pulse_ev(2);
    chkb("sleeping", 1'b0, sleeping);
    wr(8, 8'h40);
    pulse_ev(3);
    chkb("sleeping", 1'b1, sleeping);
    wr(8, 8'h02);
    chkb("wakeup drive", 1'b1, wake);
    rd(9);
    chkb("wakeup status", 1'b1, d[1]);
    settle;
    chkb("sleeping", 1'b0, sleeping);
    for (int a = 0; a < 8; a++) begin
      txi = a;
      rd(a);
      chk("byte", bx[a], d);
      chk("tx byte", bx[a], txb);
    end
    tally_and_finish;
  end
endmodule
`default_nettype wire
